// *** hw/level_sync.sv ***
// Purpose: Three-stage synchroniser for a level from another domain
// Assumes: Input may change at any time
// Notes:   A change is taken once stages two and three agree
`timescale 1ns/1ps

module level_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Level
    input  wire logic async_i,
    output logic      level_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } state_t;

    state_t state;
    state_t next_state;

    always_comb begin
        next_state    = state;
        next_state.s1 = async_i;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // First stage feeds only the second
        if (state.s2 == state.s3) begin
            next_state.q = state.s3;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level_o = state.q;

endmodule : level_sync

// *** hw/limit_summary.sv ***
// Purpose: Folds per-channel and per-window limit results into two fail summaries
// Assumes: Results are valid in the cycle of the completion pulse
// Notes:   Summaries are held between measurements
`timescale 1ns/1ps
`include "progress_consts.svh"

module limit_summary (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Measurement results
    input  wire logic                     done_i,
    input  wire progress_pkg::limit_results_t res_i,
    // Summaries
    output logic                          lower_fail_o,
    output logic                          upper_fail_o
);

    typedef struct packed {
        logic lower;
        logic upper;
    } state_t;

    state_t state;
    state_t next_state;

    always_comb begin
        next_state = state;
        if (done_i) begin
            // Disabled tests never report a failure
            next_state.lower = |(res_i.lower_enable & res_i.lower_fail); // RULE11 RULE12
            next_state.upper = |(res_i.upper_enable & res_i.upper_fail); // RULE13 RULE14
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state; // RULE18
        end
    end

    assign lower_fail_o = state.lower;
    assign upper_fail_o = state.upper;

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !done_i |=> ($stable(lower_fail_o) && $stable(upper_fail_o));
    endproperty
    a_hold: assert property (p_hold) else $error("Limit summary changed without completion"); // RULE18

    property p_lower;
        @(posedge clk_i) disable iff (!rst_n_i)
        done_i |=> (lower_fail_o == $past(|(res_i.lower_enable & res_i.lower_fail)));
    endproperty
    a_lower: assert property (p_lower) else $error("Lower fail summary wrong"); // RULE11

    property p_upper;
        @(posedge clk_i) disable iff (!rst_n_i)
        done_i |=> (upper_fail_o == $past(|(res_i.upper_enable & res_i.upper_fail)));
    endproperty
    a_upper: assert property (p_upper) else $error("Upper fail summary wrong"); // RULE13

endmodule : limit_summary

// *** hw/measurement_progress_status.sv ***
// Purpose: Measurement progress condition register with AXI4-Lite access
// Assumes: Event inputs are one-cycle pulses on clk_i; sensor read flag is asynchronous
// Notes:   Interrupt status is sticky, cleared by reading it
// Function
// (RULE1) Set bit 0 when zeroing starts
// (RULE2) Set bit 0 when calibration starts
// (RULE3) Combined query sets bit 0 at zeroing start
// (RULE4) Clear bit 0 when operation completes
// (RULE5) Bit 4 high while measure_in_progress
// (RULE6) Clear bit 4 when measurement finishes
// (RULE7) Set bit 5 entering trigger wait
// (RULE8) Clear bit 5 entering idle
// (RULE9) Bit 10 set during sensor memory read
// (RULE10) Bit 10 clear when no read
// (RULE11) Set bit 11 on lower limit fail
// (RULE12) Clear bit 11 when disabled or passing
// (RULE13) Set bit 12 on upper limit fail
// (RULE14) Clear bit 12 when disabled or passing
// (RULE15) Bits 0,4,5 summarise lower registers
// (RULE16) Bits 11,12 summarise limit-fail registers
// (RULE17) Unused bits always read zero
// (RULE18) Limit bits change only at completion
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "progress_consts.svh"

module measurement_progress_status (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    // Process events
    input  wire progress_pkg::cal_events_t    cal_i,
    input  wire progress_pkg::meas_events_t   meas_i,
    input  wire progress_pkg::limit_results_t limits_i,
    // AXI4-Lite write address
    input  wire logic [3:0]                   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]                   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Interrupt and live view
    output logic                              irq_o,
    output logic [15:0]                       condition_o
);

    typedef struct packed {
        logic                    zero_cal;
        logic                    measure_in_progress;
        logic                    wait_trig;
        logic [1:0]              ctrl;
        logic [15:0]             int_status;
        logic [15:0]             int_mask;
        logic [15:0]             prev_cond;
        logic                    aw_held;
        logic [3:0]              aw_addr;
        logic                    w_held;
        logic [31:0]             w_data;
        logic [3:0]              w_strb;
        progress_pkg::bus_phase_t wphase;
        progress_pkg::bus_phase_t rphase;
        logic [1:0]              bresp;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } state_t;

    state_t state;
    state_t next_state;

    logic        sense_read;
    logic        lower_fail;
    logic        upper_fail;
    logic [15:0] cond;
    logic        cal_start;

    // Sensor memory reader runs on its own timing
    level_sync u_sense_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (meas_i.sense_read_active),
        .level_o (sense_read)
    );

    limit_summary u_limits (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .done_i       (meas_i.measure_done),
        .res_i        (limits_i),
        .lower_fail_o (lower_fail),
        .upper_fail_o (upper_fail)
    );

    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] ofs);
        addr_hit = (a[3:2] == ofs[3:2]);
    endfunction : addr_hit

    function automatic logic addr_known(input logic [3:0] a);
        addr_known = addr_hit(a, `OFS_CONDITION) | addr_hit(a, `OFS_CTRL)
                   | addr_hit(a, `OFS_INT_STATUS) | addr_hit(a, `OFS_INT_MASK);
    endfunction : addr_known

    // Combined query starts with its zeroing phase
    assign cal_start = cal_i.zero_once_cmd | cal_i.selfcal_once_cmd
                     | cal_i.zero_cal_all_cmd; // RULE1 RULE2 RULE3

    always_comb begin
        cond                    = 16'h0000; // RULE17
        cond[`BIT_ZERO_CAL]     = state.zero_cal; // RULE15
        cond[`BIT_MEASURE]      = state.measure_in_progress; // RULE15
        cond[`BIT_WAIT_TRIG]    = state.wait_trig; // RULE15
        cond[`BIT_SENSE_READ]   = sense_read; // RULE9 RULE10
        cond[`BIT_LOWER_FAIL]   = lower_fail; // RULE16
        cond[`BIT_UPPER_FAIL]   = upper_fail; // RULE16
    end

    always_comb begin
        next_state = state;

        // Start wins over done if both arrive together, a new operation is running
        if (cal_start) begin
            next_state.zero_cal = 1'b1; // RULE1 RULE2 RULE3
        end else if (cal_i.zero_cal_done) begin
            next_state.zero_cal = 1'b0; // RULE4
        end
        if (meas_i.measure_start) begin
            next_state.measure_in_progress = 1'b1; // RULE5
        end else if (meas_i.measure_done) begin
            next_state.measure_in_progress = 1'b0; // RULE6
        end
        if (meas_i.trig_wait_enter) begin
            next_state.wait_trig = 1'b1; // RULE7
        end else if (meas_i.idle_enter) begin
            next_state.wait_trig = 1'b0; // RULE8
        end

        // Write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end

        // Read clears interrupt status; new rising edges set it in the same cycle
        next_state.prev_cond = cond;
        if (state.rphase == progress_pkg::BUS_IDLE && s_axi_arvalid
            && addr_hit(s_axi_araddr, `OFS_INT_STATUS)) begin
            next_state.int_status = 16'h0000;
        end

        if (state.wphase == progress_pkg::BUS_IDLE && state.aw_held && state.w_held) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.wphase  = progress_pkg::BUS_WRESP;
            next_state.bresp   = addr_known(state.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            if (addr_hit(state.aw_addr, `OFS_CTRL) && state.w_strb[0]) begin
                next_state.ctrl = state.w_data[1:0];
            end
            if (addr_hit(state.aw_addr, `OFS_INT_MASK)) begin
                if (state.w_strb[0]) begin
                    next_state.int_mask[7:0] = state.w_data[7:0];
                end
                if (state.w_strb[1]) begin
                    next_state.int_mask[15:8] = state.w_data[15:8];
                end
            end
        end else if (state.wphase == progress_pkg::BUS_WRESP && s_axi_bready) begin
            next_state.wphase = progress_pkg::BUS_IDLE;
        end

        case (state.rphase)
            progress_pkg::BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    next_state.rphase = progress_pkg::BUS_RRESP;
                    next_state.rresp  = addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                    next_state.rdata  = 32'h0000_0000;
                    if (addr_hit(s_axi_araddr, `OFS_CONDITION)) begin
                        next_state.rdata[15:0] = cond;
                    end else if (addr_hit(s_axi_araddr, `OFS_CTRL)) begin
                        next_state.rdata[1:0] = state.ctrl;
                    end else if (addr_hit(s_axi_araddr, `OFS_INT_STATUS)) begin
                        next_state.rdata[15:0] = state.int_status;
                    end else if (addr_hit(s_axi_araddr, `OFS_INT_MASK)) begin
                        next_state.rdata[15:0] = state.int_mask;
                    end
                end
            end
            progress_pkg::BUS_RRESP: begin
                if (s_axi_rready) begin
                    next_state.rphase = progress_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_state.rphase = progress_pkg::BUS_IDLE;
            end
        endcase

        // Set beats clear: rising condition bits, gated by ctrl bit 0 (event enable)
        if (state.ctrl[0]) begin
            next_state.int_status = next_state.int_status
                                  | (cond & ~state.prev_cond & `COND_USED_MASK);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state          <= '0;
            state.ctrl     <= `CTRL_RESET;
            state.int_mask <= `MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = !state.aw_held;
    assign s_axi_wready  = !state.w_held;
    assign s_axi_bvalid  = (state.wphase == progress_pkg::BUS_WRESP);
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = (state.rphase == progress_pkg::BUS_IDLE);
    assign s_axi_rvalid  = (state.rphase == progress_pkg::BUS_RRESP);
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;
    assign irq_o         = |(state.int_status & state.int_mask);
    assign condition_o   = cond;

    property p_cal_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        cal_start |=> condition_o[0];
    endproperty
    a_cal_set: assert property (p_cal_set) else $error("Bit 0 not set at cal start"); // RULE1

    property p_cal_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cal_i.zero_cal_done && !cal_start) |=> !condition_o[0];
    endproperty
    a_cal_clr: assert property (p_cal_clr) else $error("Bit 0 not cleared at cal end"); // RULE4

    property p_meas;
        @(posedge clk_i) disable iff (!rst_n_i)
        meas_i.measure_start |=> condition_o[4];
    endproperty
    a_meas: assert property (p_meas) else $error("Bit 4 not set at start"); // RULE5

    property p_meas_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (condition_o[4] && !meas_i.measure_done) |=> condition_o[4];
    endproperty
    a_meas_hold: assert property (p_meas_hold) else $error("Bit 4 dropped early"); // RULE5

    property p_meas_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (meas_i.measure_done && !meas_i.measure_start) |=> !condition_o[4];
    endproperty
    a_meas_clr: assert property (p_meas_clr) else $error("Bit 4 not cleared"); // RULE6

    property p_trig;
        @(posedge clk_i) disable iff (!rst_n_i)
        meas_i.trig_wait_enter |=> condition_o[5];
    endproperty
    a_trig: assert property (p_trig) else $error("Bit 5 not set"); // RULE7

    property p_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        (meas_i.idle_enter && !meas_i.trig_wait_enter) |=> !condition_o[5];
    endproperty
    a_idle: assert property (p_idle) else $error("Bit 5 not cleared"); // RULE8

    property p_sense;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(meas_i.sense_read_active) ##1 meas_i.sense_read_active [*3] |=> condition_o[10];
    endproperty
    a_sense: assert property (p_sense) else $error("Bit 10 not following read"); // RULE9

    property p_unused;
        @(posedge clk_i) disable iff (!rst_n_i)
        (condition_o & ~`COND_USED_MASK) == 16'h0000;
    endproperty
    a_unused: assert property (p_unused) else $error("Unused condition bit set"); // RULE17

endmodule : measurement_progress_status

// *** shared/progress_consts.svh ***
// Purpose: Offsets, field positions and reset values of the progress status block
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes:   Offsets of the register window are locally chosen
`ifndef PROGRESS_CONSTS_SVH
`define PROGRESS_CONSTS_SVH

`define OFS_CONDITION      4'h0
`define OFS_CTRL           4'h4
`define OFS_INT_STATUS     4'h8
`define OFS_INT_MASK       4'hc

`define BIT_ZERO_CAL       0
`define BIT_MEASURE        4
`define BIT_WAIT_TRIG      5
`define BIT_SENSE_READ     10
`define BIT_LOWER_FAIL     11
`define BIT_UPPER_FAIL     12

`define COND_USED_MASK     16'h1c31
`define CTRL_RESET         2'h0
`define MASK_RESET         16'h0000

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// *** shared/progress_pkg.sv ***
// Purpose: Types of the progress status block
// Assumes: Constants come from progress_consts.svh
// Notes:   No constants here, only types
package progress_pkg;

    typedef struct packed {
        logic       zero_once_cmd;
        logic       selfcal_once_cmd;
        logic       zero_cal_all_cmd;
        logic       zero_cal_done;
    } cal_events_t;

    typedef struct packed {
        logic       measure_start;
        logic       measure_done;
        logic       trig_wait_enter;
        logic       idle_enter;
        logic       sense_read_active;
    } meas_events_t;

    typedef struct packed {
        logic [3:0] lower_enable;
        logic [3:0] lower_fail;
        logic [3:0] upper_enable;
        logic [3:0] upper_fail;
    } limit_results_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRESP,
        BUS_RRESP
    } bus_phase_t;

endpackage : progress_pkg

// *** sim/measurement_progress_status_tb.sv ***
// Purpose: Self-checking bench for the measurement progress condition register
// Assumes: Event pulses last one cycle; AXI4-Lite master with one transfer at a time
// Notes:   Row table covers event sequences; bus, interrupt and reset cases follow it
`timescale 1ns/1ps
`include "progress_consts.svh"

module measurement_progress_status_tb;
    typedef struct {
        progress_pkg::cal_events_t    c;
        progress_pkg::meas_events_t   m;
        progress_pkg::limit_results_t l;
        logic [15:0]                  e;
    } row_t;

    logic                         clk_i;
    logic                         rst_n_i;
    progress_pkg::cal_events_t    cal_i;
    progress_pkg::meas_events_t   meas_i;
    progress_pkg::limit_results_t limits_i;
    logic [3:0]                   awaddr;
    logic                         awvalid;
    logic                         awready;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         wvalid;
    logic                         wready;
    logic [1:0]                   bresp;
    logic                         bvalid;
    logic                         bready;
    logic [3:0]                   araddr;
    logic                         arvalid;
    logic                         arready;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic                         rvalid;
    logic                         rready;
    logic                         irq_o;
    logic [15:0]                  condition_o;
    int                           miscompares;
    int                           compares;
    int                           cycles;
    logic [31:0]                  rd;

    // Limits stay applied after each row so later rows see stale results
    row_t rows [12] = '{
        '{4'h8, 5'h00, 16'h0000, 16'h0001},
        '{4'h1, 5'h00, 16'h0000, 16'h0000},
        '{4'h4, 5'h00, 16'h0000, 16'h0001},
        '{4'h1, 5'h00, 16'h0000, 16'h0000},
        '{4'h2, 5'h00, 16'h0000, 16'h0001},
        '{4'h1, 5'h00, 16'h0000, 16'h0000},
        '{4'h0, 5'h10, 16'h0000, 16'h0010},
        '{4'h0, 5'h04, 16'h0000, 16'h0030},
        '{4'h0, 5'h08, 16'h110f, 16'h0820},
        '{4'h0, 5'h02, 16'hf0f0, 16'h0800},
        '{4'h0, 5'h08, 16'hf022, 16'h1000},
        '{4'h0, 5'h08, 16'h0f43, 16'h0000}
    };

    measurement_progress_status uut (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .cal_i        (cal_i),
        .meas_i       (meas_i),
        .limits_i     (limits_i),
        .s_axi_awaddr (awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata  (wdata),
        .s_axi_wstrb  (wstrb),
        .s_axi_wvalid (wvalid),
        .s_axi_wready (wready),
        .s_axi_bresp  (bresp),
        .s_axi_bvalid (bvalid),
        .s_axi_bready (bready),
        .s_axi_araddr (araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata  (rdata),
        .s_axi_rresp  (rresp),
        .s_axi_rvalid (rvalid),
        .s_axi_rready (rready),
        .irq_o        (irq_o),
        .condition_o  (condition_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // A hang would otherwise stall the run with no verdict
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Ready is combinational from state, so its value one ns after an edge holds to the next
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        bit aw_done;
        bit w_done;
        bit aw_hit;
        bit w_hit;
        bit b_hit;
        logic [1:0] resp;
        aw_done = 0;
        w_done = 0;
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            #1;
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge clk_i);
            if (aw_hit) begin
                awvalid <= 1'b0;
                aw_done = 1;
            end
            if (w_hit) begin
                wvalid <= 1'b0;
                w_done = 1;
            end
        end
        do begin
            #1;
            b_hit = bvalid;
            resp = bresp;
            @(posedge clk_i);
        end while (!b_hit);
        bready <= 1'b0;
        check("bresp", {30'h0, `RESP_OKAY}, {30'h0, resp});
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        bit hit;
        logic [1:0] resp;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            #1;
            hit = arready;
            @(posedge clk_i);
        end while (!hit);
        arvalid <= 1'b0;
        do begin
            #1;
            hit = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clk_i);
        end while (!hit);
        rready <= 1'b0;
        check("rresp", {30'h0, `RESP_OKAY}, {30'h0, resp});
    endtask : axi_read

    task automatic pulse(input logic [3:0] c, input logic [4:0] m, input logic [15:0] l);
        @(posedge clk_i);
        cal_i <= c;
        meas_i <= m;
        limits_i <= l;
        @(posedge clk_i);
        cal_i <= '0;
        meas_i <= '0;
        #1;
    endtask : pulse

    initial begin
        rst_n_i = 1'b0;
        cal_i = '0;
        meas_i = '0;
        limits_i = '0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        axi_read(`OFS_CTRL, rd);
        check("ctrl reset", {30'h0, `CTRL_RESET}, rd);
        axi_read(`OFS_INT_MASK, rd);
        check("mask reset", {16'h0, `MASK_RESET}, rd);
        axi_read(`OFS_CONDITION, rd);
        check("condition reset", 32'h0, rd);
        $display("test reset values done");

        for (int i = 0; i < 12; i++) begin
            pulse(rows[i].c, rows[i].m, rows[i].l);
            check($sformatf("row %0d", i), {16'h0, rows[i].e}, {16'h0, condition_o});
        end
        $display("test event rows done");

        @(posedge clk_i);
        meas_i.sense_read_active <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        check("sense read set", 32'h400, {16'h0, condition_o});
        @(posedge clk_i);
        meas_i.sense_read_active <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        check("sense read clear", 32'h0, {16'h0, condition_o});
        $display("test sensor read done");

        axi_read(`OFS_INT_STATUS, rd);
        check("status events disabled", 32'h0, rd);
        axi_write(`OFS_CTRL, 32'h1);
        axi_read(`OFS_CTRL, rd);
        check("ctrl write", 32'h1, rd);
        axi_write(`OFS_INT_MASK, 32'h1);
        #1;
        check("irq idle", 32'h0, {31'h0, irq_o});
        pulse(4'h8, 5'h00, 16'h0);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq raised", 32'h1, {31'h0, irq_o});
        axi_read(`OFS_INT_STATUS, rd);
        check("status zeroing", 32'h1, rd);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq cleared", 32'h0, {31'h0, irq_o});
        pulse(4'h1, 5'h00, 16'h0);
        axi_write(`OFS_INT_MASK, 32'h0);
        pulse(4'h0, 5'h10, 16'h0);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq masked", 32'h0, {31'h0, irq_o});
        axi_read(`OFS_INT_STATUS, rd);
        check("status measure", 32'h10, rd);
        axi_write(`OFS_CONDITION, 32'hffff_ffff);
        axi_read(`OFS_CONDITION, rd);
        check("condition read only", 32'h10, rd);
        $display("test bus and interrupt done");

        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check("condition in reset", 32'h0, {16'h0, condition_o});
        check("irq in reset", 32'h0, {31'h0, irq_o});
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        pulse(4'h2, 5'h00, 16'h0);
        check("zeroing after reset", 32'h1, {16'h0, condition_o});
        $display("test second reset done");
        summarize();
    end
endmodule : measurement_progress_status_tb
